// ---- sbse_alu.sv ----
// subtract-with-borrow datapath and flag generation
`timescale 1ns/1ps
module sbse_alu (
    input wire logic [7:0] acc,
    input wire logic [7:0] operand,
    input wire logic carry_in,
    output logic [7:0] result,
    output sbse_pkg::sbse_flags_type flags
);
    logic [8:0] full;
    logic [4:0] low;

    // borrow is the inverted carry, so carry set means no borrow
    assign full = {1'b0, acc} - {1'b0, operand} - {8'h00, ~carry_in};
    assign low = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, ~carry_in};
    assign result = full[7:0];
    assign flags.c = ~full[8];
    assign flags.dc = ~low[4];
    assign flags.z = (full[7:0] == 8'h00);
    assign flags.n = full[7];
    assign flags.ov = (acc[7] != operand[7]) && (full[7] != acc[7]);
endmodule // sbse_alu

// ---- sbse_exec.sv ----
// apb-driven executor for subtract-with-borrow and sleep
`timescale 1ns/1ps

// Notes on behaviour
// (RL1) subtract-with-borrow computes work minus file minus inverted carry and updates n, ov, c, dc, z.
// (RL2) with destination bit 0 the result goes to the working register only.
// (RL3) with destination bit 1 the result is written back to the file register.
// (RL4) with access bit 0 the file address lies in the access bank.
// (RL5) with access bit 1 the bank pointer selects the file bank.
// (RL6) extended set on, access bit 0 and address up to 95 gives indexed literal offset.
// (RL7) a watchdog wake from sleep clears the time expiry flag.
// (RL8) sleep clears sleep entry, sets time expiry, clears the watchdog and halts the core.
module sbse_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic core_halted,
    output logic osc_running
);
    typedef enum logic [1:0] {
        st_idle,
        st_fetch,
        st_exec
    } sbse_state_type;

    sbse_state_type state;
    logic [15:0] instr;
    logic [7:0] work;
    sbse_pkg::sbse_flags_type flags;
    logic time_expiry_flag;
    logic sleep_entry_flag;
    logic [3:0] bank_pointer;
    logic ext_en;
    logic wd_en;
    logic [11:0] index_base;
    logic [11:0] mem_win_addr;
    logic [7:0] wd_pre;
    logic [3:0] wd_post;

    logic accept;
    logic wr_acc;
    logic sleep_cmd;
    logic sub_cmd;
    logic wd_expire;
    logic wake_req;
    logic [7:0] file_addr;
    logic [11:0] exec_addr;
    logic [11:0] mem_addr;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] alu_result;
    sbse_pkg::sbse_flags_type alu_flags;
    logic busy;
    logic [31:0] next_prdata;
    logic next_slverr;

    // ********************************
    // bus handshake
    // ********************************
    // one wait state lets the registered memory read settle
    assign busy = (state != st_idle);
    assign accept = psel && penable && pready;
    assign wr_acc = accept && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready && !busy;
            prdata <= next_prdata;
            pslverr <= next_slverr;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (paddr)
            sbse_pkg::REG_INSTR: next_prdata = {16'h0000, instr};
            sbse_pkg::REG_WORK: next_prdata = {24'h00_0000, work};
            sbse_pkg::REG_STATUS: begin
                next_prdata[sbse_pkg::ST_FLAGS_LSB +: 5] = flags;
                next_prdata[sbse_pkg::ST_SLEEP_ENTRY] = sleep_entry_flag;
                next_prdata[sbse_pkg::ST_TIME_EXPIRY] = time_expiry_flag;
                next_prdata[sbse_pkg::ST_BUSY] = busy;
                next_prdata[sbse_pkg::ST_SLEEPING] = core_halted;
            end
            sbse_pkg::REG_BANK: next_prdata = {28'h000_0000, bank_pointer};
            sbse_pkg::REG_CTRL: begin
                next_prdata[sbse_pkg::CTRL_EXT_EN] = ext_en;
                next_prdata[sbse_pkg::CTRL_WD_EN] = wd_en;
            end
            sbse_pkg::REG_INDEX_BASE: next_prdata = {20'h0_0000, index_base};
            sbse_pkg::REG_MEM_ADDR: next_prdata = {20'h0_0000, mem_win_addr};
            sbse_pkg::REG_MEM_DATA: next_prdata = {24'h00_0000, mem_rdata};
            sbse_pkg::REG_WATCHDOG: next_prdata = {20'h0_0000, wd_post, wd_pre};
            default: next_slverr = 1'b1;
        endcase
    end

    // ********************************
    // decode and addressing
    // ********************************
    assign sleep_cmd = wr_acc && (paddr == sbse_pkg::REG_INSTR)
        && !core_halted && (pwdata[15:0] == sbse_pkg::OPC_SLEEP);
    assign sub_cmd = wr_acc && (paddr == sbse_pkg::REG_INSTR)
        && !core_halted && (pwdata[15:10] == sbse_pkg::OPC_SUB_BORROW);
    assign wake_req = wr_acc && (paddr == sbse_pkg::REG_CTRL)
        && pwdata[sbse_pkg::CTRL_WAKE];
    assign file_addr = instr[7:0];

    always_comb begin
        exec_addr = {bank_pointer, file_addr};
        if (!instr[sbse_pkg::INSTR_ACCESS]) begin
            if (ext_en && (file_addr <= sbse_pkg::INDEXED_LIMIT)) begin
                // (RL6) indexed literal offset
                exec_addr = index_base + {4'h0, file_addr};
            end else if (file_addr < sbse_pkg::ACCESS_SPLIT) begin
                // (RL4) access bank low part
                exec_addr = {sbse_pkg::ACCESS_LOW_BANK, file_addr};
            end else begin
                // (RL4) access bank high part
                exec_addr = {sbse_pkg::ACCESS_HIGH_BANK, file_addr};
            end
        end else begin
            // (RL5) bank pointer selects bank
            exec_addr = {bank_pointer, file_addr};
        end
    end

    // memory port belongs to the executor while busy, else to the window
    assign mem_addr = busy ? exec_addr : mem_win_addr;
    // (RL3) write back to file register
    assign mem_wr = ((state == st_exec) && instr[sbse_pkg::INSTR_DEST])
        || (wr_acc && (paddr == sbse_pkg::REG_MEM_DATA));
    assign mem_wdata = busy ? alu_result : pwdata[7:0];

    sbse_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .addr(mem_addr),
        .wr_en(mem_wr),
        .wr_data(mem_wdata),
        .rd_data(mem_rdata)
    );

    sbse_alu u_alu (
        .acc(work),
        .operand(mem_rdata),
        .carry_in(flags.c),
        .result(alu_result),
        .flags(alu_flags)
    );

    // ********************************
    // execution sequence
    // ********************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (sub_cmd) begin
                        state <= st_fetch;
                    end
                end
                st_fetch: state <= st_exec;
                st_exec: state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= sbse_pkg::INSTR_RESET;
        end else if (wr_acc && (paddr == sbse_pkg::REG_INSTR)) begin
            instr <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work <= sbse_pkg::WORK_RESET;
        end else if ((state == st_exec) && !instr[sbse_pkg::INSTR_DEST]) begin
            // (RL2) result to working register
            work <= alu_result;
        end else if (wr_acc && (paddr == sbse_pkg::REG_WORK)) begin
            work <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else if (state == st_exec) begin
            // (RL1) flags from subtraction
            flags <= alu_flags;
        end else if (wr_acc && (paddr == sbse_pkg::REG_STATUS)) begin
            flags <= pwdata[sbse_pkg::ST_FLAGS_LSB +: 5];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_pointer <= sbse_pkg::BANK_RESET;
            ext_en <= 1'b0;
            wd_en <= 1'b0;
            index_base <= sbse_pkg::INDEX_BASE_RESET;
            mem_win_addr <= 12'h000;
        end else if (wr_acc) begin
            case (paddr)
                sbse_pkg::REG_BANK: bank_pointer <= pwdata[3:0];
                sbse_pkg::REG_CTRL: begin
                    ext_en <= pwdata[sbse_pkg::CTRL_EXT_EN];
                    wd_en <= pwdata[sbse_pkg::CTRL_WD_EN];
                end
                sbse_pkg::REG_INDEX_BASE: index_base <= pwdata[11:0];
                sbse_pkg::REG_MEM_ADDR: mem_win_addr <= pwdata[11:0];
                default: ;
            endcase
        end
    end

    // ********************************
    // watchdog and sleep
    // ********************************
    assign wd_expire = wd_en && (wd_pre == sbse_pkg::WD_PRE_MAX)
        && (wd_post == sbse_pkg::WD_POST_MAX);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_pre <= 8'h00;
            wd_post <= 4'h0;
        end else if (sleep_cmd || !wd_en) begin
            // (RL8) clear watchdog and postscaler
            wd_pre <= 8'h00;
            wd_post <= 4'h0;
        end else begin
            wd_pre <= wd_pre + 8'h01;
            if (wd_pre == sbse_pkg::WD_PRE_MAX) begin
                wd_post <= wd_post + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_expiry_flag <= sbse_pkg::TIME_EXPIRY_RESET;
            sleep_entry_flag <= sbse_pkg::SLEEP_ENTRY_RESET;
        end else if (sleep_cmd) begin
            // (RL8) sleep flag update
            sleep_entry_flag <= 1'b0;
            time_expiry_flag <= 1'b1;
        end else if (core_halted && wd_expire) begin
            // (RL7) watchdog wake clears flag
            time_expiry_flag <= 1'b0;
        end
    end

    // the oscillator only stops with the core; the watchdog keeps pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_halted <= 1'b0;
            osc_running <= 1'b1;
        end else if (sleep_cmd) begin
            // (RL8) halt core, stop oscillator
            core_halted <= 1'b1;
            osc_running <= 1'b0;
        end else if (core_halted && (wd_expire || wake_req)) begin
            core_halted <= 1'b0;
            osc_running <= 1'b1;
        end
    end
endmodule // sbse_exec

// ---- sbse_exec_sva.sv ----
// checker for the executor bus handshake and sleep outputs
`timescale 1ns/1ps
module sbse_exec_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_halted,
    input wire logic osc_running
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic commit;
    assign commit = psel && penable && pready;
    a_sleep_halts: assert property (commit && pwrite && !core_halted
        && paddr == sbse_pkg::REG_INSTR
        && pwdata[15:0] == sbse_pkg::OPC_SLEEP |=> core_halted)
        else $error("sleep write did not halt the core");
    a_osc_follows: assert property (osc_running == !core_halted)
        else $error("oscillator state disagrees with halt");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_first_wait: assert property (psel && $rose(penable) |-> !pready)
        else $error("no wait state in first access cycle");
    a_wait_bounded: assert property (psel && $rose(penable)
        |-> ##[1:8] pready) else $error("access never completed");
    a_err_unmapped: assert property (commit
        && paddr > sbse_pkg::REG_WATCHDOG |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (commit && paddr[1:0] == 2'b00
        && paddr <= sbse_pkg::REG_WATCHDOG |-> !pslverr)
        else $error("mapped access refused");
endmodule // sbse_exec_sva

// ---- sbse_mem.sv ----
// data file memory, single port, registered read
`timescale 1ns/1ps
module sbse_mem (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] addr,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] cells [0:4095];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            cells[addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= cells[addr];
        end
    end
endmodule // sbse_mem

// ---- sbse_pkg.sv ----
// constants and types shared by the subtract-with-borrow and sleep executor
package sbse_pkg;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam logic [11:0] REG_INSTR = 12'h000;
    localparam logic [11:0] REG_WORK = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_BANK = 12'h00C;
    localparam logic [11:0] REG_CTRL = 12'h010;
    localparam logic [11:0] REG_INDEX_BASE = 12'h014;
    localparam logic [11:0] REG_MEM_ADDR = 12'h018;
    localparam logic [11:0] REG_MEM_DATA = 12'h01C;
    localparam logic [11:0] REG_WATCHDOG = 12'h020;

    // ********************************
    // field positions
    // ********************************
    localparam int ST_FLAGS_LSB = 0;
    localparam int ST_SLEEP_ENTRY = 5;
    localparam int ST_TIME_EXPIRY = 6;
    localparam int ST_BUSY = 7;
    localparam int ST_SLEEPING = 8;
    localparam int CTRL_EXT_EN = 0;
    localparam int CTRL_WD_EN = 1;
    localparam int CTRL_WAKE = 2;
    localparam int INSTR_DEST = 9;
    localparam int INSTR_ACCESS = 8;

    // ********************************
    // encodings and limits
    // ********************************
    localparam logic [5:0] OPC_SUB_BORROW = 6'h15;
    localparam logic [15:0] OPC_SLEEP = 16'h0003;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] WD_PRE_MAX = 8'hFF;
    localparam logic [3:0] WD_POST_MAX = 4'hF;

    // ********************************
    // reset values
    // ********************************
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [11:0] INDEX_BASE_RESET = 12'h000;
    localparam logic [15:0] INSTR_RESET = 16'h0000;
    localparam logic TIME_EXPIRY_RESET = 1'b1;
    localparam logic SLEEP_ENTRY_RESET = 1'b1;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } sbse_flags_type;

endpackage

// ---- tb_top.sv ----
// self-checking bench for the subtract-with-borrow and sleep executor
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [11:0] ma;
        logic [15:0] ins;
        logic [7:0] mem;
        logic [7:0] w;
        logic [7:0] st;
        logic [7:0] ew;
        logic [7:0] em;
        logic [7:0] est;
    } sbse_case_type;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, err;
    logic core_halted, osc_running;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int num_errors = 0;
    int checks = 0;
    int n;
    sbse_case_type cases [6];
    always #2.5 pclk = ~pclk;
    sbse_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_halted(core_halted), .osc_running(osc_running));
    task final_report;
        $display("num_errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****************
    // apb transfer, bounded wait on pready
    // ****************
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 64);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 64) begin num_errors++; final_report(); end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        // bank 2 for a=1, index base 0x300 for indexed mode
        cases = '{'{8'h00, 12'h203, 16'h5703, 8'h03, 8'h02, 8'h01, 8'h02,
                    8'hFF, 8'h70},
                  '{8'h00, 12'h005, 16'h5405, 8'h02, 8'h05, 8'h01, 8'h03,
                    8'h02, 8'h63},
                  '{8'h00, 12'hF80, 16'h5680, 8'h01, 8'h02, 8'h00, 8'h02,
                    8'h00, 8'h67},
                  '{8'h01, 12'h35F, 16'h565F, 8'h01, 8'h02, 8'h00, 8'h02,
                    8'h00, 8'h67},
                  '{8'h01, 12'hF60, 16'h5660, 8'h01, 8'h02, 8'h00, 8'h02,
                    8'h00, 8'h67},
                  '{8'h00, 12'h207, 16'h5507, 8'h01, 8'h80, 8'h01, 8'h7F,
                    8'h01, 8'h69}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, sbse_pkg::REG_STATUS, 32'h0);
        `CHK(q, 32'h0000_0060)
        apb(1'b1, sbse_pkg::REG_WATCHDOG, 32'h0000_0FFF);
        apb(1'b0, sbse_pkg::REG_WATCHDOG, 32'h0);
        `CHK(q, 32'h0000_0000)
        apb(1'b1, 12'h040, 32'h0000_00FF);
        `CHK(err, 1'b1)
        apb(1'b0, 12'h040, 32'h0);
        `CHK({err, q}, {1'b1, 32'h0000_0000})
        apb(1'b1, sbse_pkg::REG_BANK, 32'h0000_0002);
        apb(1'b1, sbse_pkg::REG_INDEX_BASE, 32'h0000_0300);
        foreach (cases[i]) begin
            apb(1'b1, sbse_pkg::REG_CTRL, {24'h00_0000, cases[i].ctrl});
            apb(1'b1, sbse_pkg::REG_MEM_ADDR, {20'h0_0000, cases[i].ma});
            apb(1'b1, sbse_pkg::REG_MEM_DATA, {24'h00_0000, cases[i].mem});
            apb(1'b1, sbse_pkg::REG_WORK, {24'h00_0000, cases[i].w});
            apb(1'b1, sbse_pkg::REG_STATUS, {24'h00_0000, cases[i].st});
            apb(1'b1, sbse_pkg::REG_INSTR, {16'h0000, cases[i].ins});
            apb(1'b0, sbse_pkg::REG_WORK, 32'h0);
            `CHK(q, {24'h00_0000, cases[i].ew})
            apb(1'b0, sbse_pkg::REG_MEM_DATA, 32'h0);
            `CHK(q, {24'h00_0000, cases[i].em})
            apb(1'b0, sbse_pkg::REG_STATUS, 32'h0);
            `CHK(q, {24'h00_0000, cases[i].est})
        end
        apb(1'b1, sbse_pkg::REG_CTRL, 32'h0000_0002);
        apb(1'b1, sbse_pkg::REG_INSTR, 32'h0000_0003);
        `CHK({core_halted, osc_running}, 2'b10)
        apb(1'b0, sbse_pkg::REG_STATUS, 32'h0);
        `CHK(q & 32'h0000_01E0, 32'h0000_0140)
        apb(1'b0, sbse_pkg::REG_WATCHDOG, 32'h0);
        `CHK(q < 32'h0000_0010, 1'b1)
        n = 0;
        while (core_halted !== 1'b0 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 5000) begin num_errors++; final_report(); end
        apb(1'b0, sbse_pkg::REG_STATUS, 32'h0);
        `CHK(q & 32'h0000_01E0, 32'h0000_0000)
        // software wake keeps the expiry flag, since no timeout happened
        apb(1'b1, sbse_pkg::REG_CTRL, 32'h0000_0000);
        apb(1'b1, sbse_pkg::REG_INSTR, 32'h0000_0003);
        `CHK(core_halted, 1'b1)
        apb(1'b1, sbse_pkg::REG_CTRL, 32'h0000_0004);
        `CHK({core_halted, osc_running}, 2'b01)
        apb(1'b0, sbse_pkg::REG_STATUS, 32'h0);
        `CHK(q & 32'h0000_01E0, 32'h0000_0040)
        final_report();
    end
endmodule // tb_top
bind sbse_exec sbse_exec_sva i_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .core_halted,
    .osc_running);
